// ---- ppc_pkg.sv ----
// Purpose: constants shared by the port pin control logic
// Assumes: byte-wide register port, 10-bit register addresses
// Notes:   offsets other than the analog data register are local choices
package ppc_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 10;
  localparam logic [9:0]  ADDR_PE_DATA    = 10'h008;
  localparam logic [9:0]  ADDR_PE_DIR     = 10'h009;
  localparam logic [9:0]  ADDR_MODE       = 10'h00B;
  localparam logic [9:0]  ADDR_CLKOUT     = 10'h00C;
  localparam logic [9:0]  ADDR_IRQCTL     = 10'h01E;
  localparam logic [9:0]  ADDR_PP_DATA    = 10'h258;
  localparam logic [9:0]  ADDR_PP_IN      = 10'h259;
  localparam logic [9:0]  ADDR_PP_DIR     = 10'h25A;
  localparam logic [9:0]  ADDR_PP_PULLEN  = 10'h25C;
  localparam logic [9:0]  ADDR_PP_POL     = 10'h25D;
  localparam logic [9:0]  ADDR_PP_IE      = 10'h25E;
  localparam logic [9:0]  ADDR_PP_IF      = 10'h25F;
  localparam logic [9:0]  ADDR_PP_IFCLR   = 10'h260;
  localparam logic [9:0]  ADDR_ROUTE      = 10'h2C7;
  localparam logic [9:0]  ADDR_ANA_DATA   = 10'h271;
  localparam logic [9:0]  ADDR_ANA_DIR    = 10'h273;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          CLK_CORE_EN_BIT = 7;
  localparam int          CLK_BUS_EN_BIT  = 6;
  localparam int          CLK_DIV_LSB     = 0;
  localparam int          CLK_DIV_W       = 4;
  localparam int          IRQ_EDGE_BIT    = 7;
  localparam int          IRQ_EN_BIT      = 6;
  localparam int          IRQ_PULL_BIT    = 0;
  localparam int          PE_CORE_PIN     = 7;
  localparam int          PE_BUS_PIN      = 4;
  localparam int          PE_IRQ_PIN      = 1;
  localparam int          PWM_CH          = 6;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_ZERO        = 8'h00;
  localparam logic [7:0]  RST_IRQCTL      = 8'h01;
  localparam logic [7:0]  RST_ANA_DATA    = 8'h00;
  localparam logic [7:0]  PP_IMPL_MASK    = 8'hBF;
  localparam logic [7:0]  PE_ALT_MASK     = 8'h6C;
  localparam logic [7:0]  PE_IN_ONLY_MASK = 8'h02;

endpackage : ppc_pkg

// ---- ppc_port_pins.sv ----
// Purpose: port pin control: pulls, pin interrupts, analog port, port E, routing
// Assumes: all pin inputs synchronous to mclk; synchronous active-high reset
// Notes:   output enables are active low (low while this block drives)
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module ppc_port_pins
  import ppc_pkg::*;
#(
  parameter int ANA_DIR_BITS = 2,
  parameter int DIV_W        = CLK_DIV_W
)(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output logic      [7:0]        regRdData,
  input  wire logic [7:0]        ppIn,
  output logic      [7:0]        ppOut,
  output logic      [7:0]        ppOutEnN,
  output logic      [7:0]        ppPullEn,
  output logic      [7:0]        ppPullDown,
  input  wire logic [5:0]        pwmOut,
  input  wire logic [5:0]        pwmChanEn,
  output logic      [5:0]        pwmAltOut,
  output logic      [5:0]        pwmAltOutEnN,
  input  wire logic [7:0]        anaIn,
  output logic      [7:0]        anaOut,
  output logic      [7:0]        anaOutEnN,
  input  wire logic [7:0]        convClaim,
  input  wire logic [7:0]        convDigInEn,
  input  wire logic [7:0]        peIn,
  output logic      [7:0]        peOut,
  output logic      [7:0]        peOutEnN,
  output logic                   pePullUp,
  input  wire logic [7:0]        periphActive,
  input  wire logic [7:0]        periphOut,
  input  wire logic [7:0]        periphOutEn,
  input  wire logic              coreRateClk,
  input  wire logic              busRateClk,
  input  wire logic              bkgdIn,
  output logic                   modeSelC,
  input  wire logic              cpuIMask,
  input  wire logic              extIrqAck,
  output logic                   extIrqReq,
  output logic                   pinIrq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (ANA_DIR_BITS < 1 || ANA_DIR_BITS > 8)
  begin : gChkAna
    $error("ANA_DIR_BITS must lie in 1..8");
  end
  if (DIV_W < 1 || DIV_W > CLK_DIV_W)
  begin : gChkDiv
    $error("DIV_W must lie in 1..CLK_DIV_W");
  end
  if (PWM_CH > 6 || CLK_DIV_LSB + CLK_DIV_W > 8)
  begin : gChkPkg
    $error("package field constants do not fit the ports");
  end
  if (PE_CORE_PIN > 7 || PE_BUS_PIN > 7 || PE_IRQ_PIN > 7)
  begin : gChkPe
    $error("port E pin numbers must lie in 0..7");
  end

  localparam logic [7:0] ANA_DIR_MASK = 8'((9'h001 << ANA_DIR_BITS) - 9'h001);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]       ppData_q,   ppData_d;
  logic [7:0]       ppDir_q,    ppDir_d;
  logic [7:0]       ppPullEn_q, ppPullEn_d;
  logic [7:0]       ppPol_q,    ppPol_d;
  logic [7:0]       ppIe_q,     ppIe_d;
  logic [7:0]       ppIf_q,     ppIf_d;
  logic [7:0]       ppPrev_q,   ppPrev_d;
  logic [7:0]       route_q,    route_d;
  logic [7:0]       anaData_q,  anaData_d;
  logic [7:0]       anaDir_q,   anaDir_d;
  logic [7:0]       peData_q,   peData_d;
  logic [7:0]       peDir_q,    peDir_d;
  logic [7:0]       clkCtl_q,   clkCtl_d;
  logic [7:0]       irqCtl_q,   irqCtl_d;
  logic             modeC_q,    modeC_d;
  logic             pe1Prev_q,  pe1Prev_d;
  logic             irqLatch_q, irqLatch_d;
  logic [DIV_W-1:0] divCnt_q,   divCnt_d;
  logic             divClk_q,   divClk_d;
  logic [7:0]       rdData_q,   rdData_d;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic [7:0]       ppDrive;
  logic [7:0]       ppEdge;
  logic [7:0]       anaDrive;
  logic [7:0]       anaRead;
  logic [7:0]       ppRead;
  logic [7:0]       peRead;
  logic [DIV_W-1:0] divSel;
  logic             busClkOut;
  logic             wrHit;

  assign divSel = clkCtl_q[CLK_DIV_LSB +: DIV_W];

  // ---------------------------------------------------------------
  // per-bit pin logic
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 8; i++)
  begin : gBit
    // port P: gpio output or modulator on its default pin
    logic pwmHere;
    logic pinOut;
    if (i < PWM_CH)
    begin : gPwm
      assign pwmHere         = pwmChanEn[i] & ~route_q[i];
      assign pwmAltOut[i]    = pwmOut[i] & route_q[i];
      assign pwmAltOutEnN[i] = ~(pwmChanEn[i] & route_q[i]);
    end
    else
    begin : gNoPwm
      assign pwmHere = 1'b0;
    end
    assign pinOut      = pwmHere ? pwmOut[i] : ppData_q[i];
    assign ppDrive[i]  = (ppDir_q[i] | pwmHere) & PP_IMPL_MASK[i];
    assign ppOut[i]    = pinOut & ppDrive[i];
    assign ppOutEnN[i] = ~ppDrive[i];
    assign ppRead[i]   = ppDir_q[i] ? ppData_q[i] : ppIn[i];
    assign ppPullEn[i] = ppPullEn_q[i] & ~ppDrive[i];
    assign ppPullDown[i] = ppPol_q[i];
    // edge toward the polarity the pull device idles away from
    assign ppEdge[i]   = ~ppDrive[i] & PP_IMPL_MASK[i] &
                         (ppPol_q[i] ? (ppIn[i] & ~ppPrev_q[i])
                                     : (~ppIn[i] & ppPrev_q[i]));

    // analog port
    assign anaDrive[i]  = anaDir_q[i] & ~convClaim[i];
    assign anaOut[i]    = anaData_q[i] & anaDrive[i];
    assign anaOutEnN[i] = ~anaDrive[i];
    // a disabled digital input reads low instead of passing a floating pad inward
    assign anaRead[i]   = anaDir_q[i] ? anaData_q[i]
                                      : (anaIn[i] & convDigInEn[i]);
  end

  // ---------------------------------------------------------------
  // port E pin muxing
  // ---------------------------------------------------------------
  // the core clock and the undivided bus clock pass straight through: switching an enable mid-phase can leave a runt pulse
  assign busClkOut = (divSel == '0) ? busRateClk : divClk_q;
  assign peRead    = (peDir_q & peData_q) | (~peDir_q & peIn);

  always_comb
  begin
    peOut    = '0;
    peOutEnN = '1;
    for (int j = 0; j < 8; j++)
    begin
      if (PE_ALT_MASK[j] && periphActive[j])
      begin
        peOut[j]    = periphOut[j] & periphOutEn[j];
        peOutEnN[j] = ~periphOutEn[j];
      end
      else if (!PE_IN_ONLY_MASK[j] && peDir_q[j])
      begin
        peOut[j]    = peData_q[j];
        peOutEnN[j] = 1'b0;
      end
    end
    if (clkCtl_q[CLK_CORE_EN_BIT])
    begin
      peOut[PE_CORE_PIN]    = coreRateClk;
      peOutEnN[PE_CORE_PIN] = 1'b0;
    end
    if (clkCtl_q[CLK_BUS_EN_BIT])
    begin
      peOut[PE_BUS_PIN]    = busClkOut;
      peOutEnN[PE_BUS_PIN] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt outputs
  // ---------------------------------------------------------------
  assign pinIrq   = |(ppIf_q & ppIe_q);
  // level mode follows the pin; edge mode holds until acknowledged
  assign extIrqReq = irqCtl_q[IRQ_EN_BIT] & ~cpuIMask &
                     (irqCtl_q[IRQ_EDGE_BIT] ? irqLatch_q
                                             : ~peIn[PE_IRQ_PIN]);
  assign pePullUp  = irqCtl_q[IRQ_PULL_BIT];
  assign modeSelC  = modeC_q;
  assign regRdData = rdData_q;
  assign wrHit     = regWrStb;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    ppData_d   = ppData_q;
    ppDir_d    = ppDir_q;
    ppPullEn_d = ppPullEn_q;
    ppPol_d    = ppPol_q;
    ppIe_d     = ppIe_q;
    ppIf_d     = ppIf_q;
    route_d    = route_q;
    anaData_d  = anaData_q;
    anaDir_d   = anaDir_q;
    peData_d   = peData_q;
    peDir_d    = peDir_q;
    clkCtl_d   = clkCtl_q;
    irqCtl_d   = irqCtl_q;
    modeC_d    = modeC_q;
    // edges are judged against the last sample, so one-cycle pulses still flag
    ppPrev_d   = ppIn;
    pe1Prev_d  = peIn[PE_IRQ_PIN];
    irqLatch_d = irqLatch_q;
    divCnt_d   = divCnt_q;
    divClk_d   = divClk_q;
    rdData_d   = '0;

    // register writes
    // pin six is absent: every port P write path except the flag clear masks its bit
    if (wrHit)
    begin
      case (regAddr)
        ADDR_PP_DATA:   ppData_d   = regWrData & PP_IMPL_MASK;
        ADDR_PP_DIR:    ppDir_d    = regWrData & PP_IMPL_MASK;
        ADDR_PP_PULLEN: ppPullEn_d = regWrData & PP_IMPL_MASK;
        ADDR_PP_POL:    ppPol_d    = regWrData & PP_IMPL_MASK;
        ADDR_PP_IE:     ppIe_d     = regWrData & PP_IMPL_MASK;
        ADDR_PP_IFCLR:  ppIf_d     = ppIf_q & ~regWrData;
        ADDR_ROUTE:     route_d    = regWrData & 8'h3F;
        ADDR_ANA_DATA:  anaData_d  = regWrData;
        ADDR_ANA_DIR:   anaDir_d   = regWrData & ANA_DIR_MASK;
        ADDR_PE_DATA:   peData_d   = regWrData;
        ADDR_PE_DIR:    peDir_d    = regWrData & ~PE_IN_ONLY_MASK;
        ADDR_CLKOUT:    clkCtl_d   = regWrData;
        ADDR_IRQCTL:    irqCtl_d   = regWrData;
        default:        ;
      endcase
    end

    // pin events set after the clear so a same-cycle event survives
    ppIf_d = ppIf_d | ppEdge;

    // external request edge latch: falling edge sets, acknowledge clears
    // the set is tested last so a fall in the acknowledge cycle is not lost
    if (extIrqAck)
    begin
      irqLatch_d = 1'b0;
    end
    if (!irqCtl_q[IRQ_EN_BIT] || !irqCtl_q[IRQ_EDGE_BIT])
    begin
      irqLatch_d = 1'b0;
    end
    else if (pe1Prev_q && !peIn[PE_IRQ_PIN])
    begin
      irqLatch_d = 1'b1;
    end

    // divided bus clock: half period of divSel cycles
    // a divider change works from the running count, so one half period may be odd
    if (divSel == '0 || divCnt_q >= divSel - 1'b1)
    begin
      divCnt_d = '0;
      divClk_d = (divSel == '0) ? 1'b0 : ~divClk_q;
    end
    else
    begin
      divCnt_d = divCnt_q + 1'b1;
    end

    // register reads, data one cycle after the strobe
    if (regRdStb)
    begin
      case (regAddr)
        ADDR_PP_DATA:   rdData_d = ppRead & PP_IMPL_MASK;
        ADDR_PP_IN:     rdData_d = ppIn & PP_IMPL_MASK;
        ADDR_PP_DIR:    rdData_d = ppDir_q;
        ADDR_PP_PULLEN: rdData_d = ppPullEn_q;
        ADDR_PP_POL:    rdData_d = ppPol_q;
        ADDR_PP_IE:     rdData_d = ppIe_q;
        ADDR_PP_IF:     rdData_d = ppIf_q;
        ADDR_ROUTE:     rdData_d = route_q;
        ADDR_ANA_DATA:  rdData_d = anaRead;
        ADDR_ANA_DIR:   rdData_d = anaDir_q;
        ADDR_PE_DATA:   rdData_d = peRead;
        ADDR_PE_DIR:    rdData_d = peDir_q;
        ADDR_CLKOUT:    rdData_d = clkCtl_q;
        ADDR_IRQCTL:    rdData_d = irqCtl_q;
        ADDR_MODE:      rdData_d = {7'h00, modeC_q};
        default:        rdData_d = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ppData_q   <= RST_ZERO;
      ppDir_q    <= RST_ZERO;
      ppPullEn_q <= RST_ZERO;
      ppPol_q    <= RST_ZERO;
      ppIe_q     <= RST_ZERO;
      ppIf_q     <= RST_ZERO;
      ppPrev_q   <= RST_ZERO;
      route_q    <= RST_ZERO;
      anaData_q  <= RST_ANA_DATA;
      anaDir_q   <= RST_ZERO;
      peData_q   <= RST_ZERO;
      peDir_q    <= RST_ZERO;
      clkCtl_q   <= RST_ZERO;
      irqCtl_q   <= RST_IRQCTL;
      pe1Prev_q  <= 1'b1;
      irqLatch_q <= 1'b0;
      divCnt_q   <= '0;
      divClk_q   <= 1'b0;
      rdData_q   <= RST_ZERO;
      // sync reset: the debug pin level is caught on each reset edge
      modeC_q    <= bkgdIn;
    end
    else
    begin
      ppData_q   <= ppData_d;
      ppDir_q    <= ppDir_d;
      ppPullEn_q <= ppPullEn_d;
      ppPol_q    <= ppPol_d;
      ppIe_q     <= ppIe_d;
      ppIf_q     <= ppIf_d;
      ppPrev_q   <= ppPrev_d;
      route_q    <= route_d;
      anaData_q  <= anaData_d;
      anaDir_q   <= anaDir_d;
      peData_q   <= peData_d;
      peDir_q    <= peDir_d;
      clkCtl_q   <= clkCtl_d;
      irqCtl_q   <= irqCtl_d;
      pe1Prev_q  <= pe1Prev_d;
      irqLatch_q <= irqLatch_d;
      divCnt_q   <= divCnt_d;
      divClk_q   <= divClk_d;
      rdData_q   <= rdData_d;
      modeC_q    <= modeC_d;
    end
  end

endmodule : ppc_port_pins

// ---- ppc_port_pins_chk.sv ----
// Purpose: port-level checks for the port pin control block
// Assumes: synchronous active-high reset on mclk
// Notes:   watches top-level ports only
`timescale 1ns/100ps
module ppc_port_pins_chk
  import ppc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       regRdStb,
  input wire logic [7:0] regRdData,
  input wire logic [7:0] ppOutEnN,
  input wire logic [7:0] ppPullEn,
  input wire logic [5:0] pwmOut,
  input wire logic [5:0] pwmChanEn,
  input wire logic [5:0] pwmAltOut,
  input wire logic [5:0] pwmAltOutEnN,
  input wire logic [7:0] anaOutEnN,
  input wire logic [7:0] convClaim,
  input wire logic [7:0] peOutEnN,
  input wire logic       pePullUp,
  input wire logic       bkgdIn,
  input wire logic       modeSelC,
  input wire logic       cpuIMask,
  input wire logic       extIrqReq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_pullOff;
    (ppPullEn & ~ppOutEnN) == 8'h00;
  endproperty
  a_pullOff: assert property (p_pullOff)
    else $error("pull device on while pin driven");
  property p_pin6;
    ppOutEnN[6] && !ppPullEn[6];
  endproperty
  a_pin6: assert property (p_pin6)
    else $error("absent pin six active");
  property p_rdIdle;
    !$past(regRdStb) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside its cycle");
  property p_anaDrive;
    (~anaOutEnN & convClaim) == 8'h00;
  endproperty
  a_anaDrive: assert property (p_anaDrive)
    else $error("analog pin driven while converter owns it");
  property p_pwmAlt;
    ((~pwmAltOutEnN & ~pwmChanEn) | ((pwmAltOut ^ pwmOut) & ~pwmAltOutEnN)) == 6'h00;
  endproperty
  a_pwmAlt: assert property (p_pwmAlt)
    else $error("alternative modulator pin wrong");
  property p_irqMask;
    cpuIMask |-> !extIrqReq;
  endproperty
  a_irqMask: assert property (p_irqMask)
    else $error("external request while masked");
  property p_irqReset;
    $past(rst) |-> pePullUp && !extIrqReq;
  endproperty
  a_irqReset: assert property (p_irqReset)
    else $error("external request not inhibited after reset");
  property p_pe1In;
    peOutEnN[1];
  endproperty
  a_pe1In: assert property (p_pe1In)
    else $error("port E pin one driven");
  property p_modeLatch;
    $past(rst) |-> modeSelC == $past(bkgdIn);
  endproperty
  a_modeLatch: assert property (p_modeLatch)
    else $error("mode bit not taken during reset");
  property p_modeHold;
    !$past(rst) |-> $stable(modeSelC);
  endproperty
  a_modeHold: assert property (p_modeHold)
    else $error("mode bit moved outside reset");
endmodule : ppc_port_pins_chk

bind ppc_port_pins ppc_port_pins_chk u_chk (.mclk(mclk), .rst(rst), .regRdStb(regRdStb),
  .regRdData(regRdData), .ppOutEnN(ppOutEnN), .ppPullEn(ppPullEn), .pwmOut(pwmOut),
  .pwmChanEn(pwmChanEn), .pwmAltOut(pwmAltOut), .pwmAltOutEnN(pwmAltOutEnN),
  .anaOutEnN(anaOutEnN), .convClaim(convClaim), .peOutEnN(peOutEnN), .pePullUp(pePullUp),
  .bkgdIn(bkgdIn), .modeSelC(modeSelC), .cpuIMask(cpuIMask), .extIrqReq(extIrqReq));

// ---- ppc_pin_model.sv ----
// Purpose: board-side model of the port P pins
// Assumes: bench supplies an external driver per pin
// Notes:   an undriven, unpulled pin wanders every cycle
`timescale 1ns/100ps
module ppc_pin_model (
  input wire logic       mclk,
  input wire logic [7:0] ppOut,
  input wire logic [7:0] ppOutEnN,
  input wire logic [7:0] ppPullEn,
  input wire logic [7:0] ppPullDown,
  input wire logic [7:0] extDrv,
  input wire logic [7:0] extEn,
  output logic     [7:0] ppIn
);
  logic [7:0] lastQ;

  always_ff @(posedge mclk)
    lastQ <= ppIn;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!ppOutEnN[i])
        ppIn[i] = ppOut[i];
      else if (extEn[i])
        ppIn[i] = extDrv[i];
      else if (ppPullEn[i])
        ppIn[i] = !ppPullDown[i];
      else
        ppIn[i] = !lastQ[i];
    end
  end
endmodule : ppc_pin_model

// ---- ppc_port_pins_bench.sv ----
// Purpose: self-checking bench for the port pin control block
// Assumes: 25 MHz mclk, synchronous reset
// Notes:   outputs are sampled at an edge, before that edge's updates
`timescale 1ns/100ps
module ppc_port_pins_bench;
  import ppc_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [7:0]        regWrData = 8'h00;
  logic              regWrStb = 1'b0, regRdStb = 1'b0;
  logic [5:0]        pwmOut = 6'h00, pwmChanEn = 6'h00;
  logic [7:0]        anaIn = 8'h00, convClaim = 8'h00, convDigInEn = 8'h00, peIn = 8'hFF;
  logic [7:0]        periphActive = 8'h00, periphOut = 8'h00, periphOutEn = 8'h00;
  logic [7:0]        extDrv = 8'hFF, extEn = 8'hFF;
  logic              coreRateClk = 1'b0, busRateClk = 1'b0, bkgdIn = 1'b1;
  logic              cpuIMask = 1'b1, extIrqAck = 1'b0;
  logic [7:0]        regRdData, ppIn, ppOut, ppOutEnN, ppPullEn, ppPullDown;
  logic [7:0]        anaOut, anaOutEnN, peOut, peOutEnN;
  logic [5:0]        pwmAltOut, pwmAltOutEnN;
  logic              pePullUp, modeSelC, extIrqReq, pinIrq;
  int                mismatches = 0, samples_checked = 0;

  initial
  begin
    forever #20 mclk = ~mclk;
  end

  ppc_port_pins uut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .ppIn(ppIn),
    .ppOut(ppOut), .ppOutEnN(ppOutEnN), .ppPullEn(ppPullEn), .ppPullDown(ppPullDown),
    .pwmOut(pwmOut), .pwmChanEn(pwmChanEn), .pwmAltOut(pwmAltOut),
    .pwmAltOutEnN(pwmAltOutEnN), .anaIn(anaIn), .anaOut(anaOut), .anaOutEnN(anaOutEnN),
    .convClaim(convClaim), .convDigInEn(convDigInEn), .peIn(peIn), .peOut(peOut),
    .peOutEnN(peOutEnN), .pePullUp(pePullUp), .periphActive(periphActive),
    .periphOut(periphOut), .periphOutEn(periphOutEn), .coreRateClk(coreRateClk),
    .busRateClk(busRateClk), .bkgdIn(bkgdIn), .modeSelC(modeSelC), .cpuIMask(cpuIMask),
    .extIrqAck(extIrqAck), .extIrqReq(extIrqReq), .pinIrq(pinIrq));

  ppc_pin_model u_pins (.mclk(mclk), .ppOut(ppOut), .ppOutEnN(ppOutEnN),
    .ppPullEn(ppPullEn), .ppPullDown(ppPullDown), .extDrv(extDrv), .extEn(extEn),
    .ppIn(ppIn));

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    cyc(1);
    regWrStb  <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdChk(input logic [9:0] a, input logic [7:0] exp, input string what);
    regAddr  <= a;
    regRdStb <= 1'b1;
    cyc(1);
    regRdStb <= 1'b0;
    cyc(1);
    chk(regRdData, exp, what);
  endtask : rdChk

  task automatic t_reset;
    rdChk(ADDR_IRQCTL, RST_IRQCTL, "irqctl reset");
    chk({7'h00, pePullUp}, 8'h01, "pe1 pull-up");
    chk({7'h00, modeSelC}, 8'h01, "mode bit");
    rdChk(ADDR_MODE, 8'h01, "mode register");
    rdChk(10'h3FF, 8'h00, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_pull;
    wr(ADDR_PP_PULLEN, 8'hFF);
    wr(ADDR_PP_POL, 8'hFF);
    chk(ppPullEn, PP_IMPL_MASK, "pull enable");
    chk(ppPullDown, PP_IMPL_MASK, "pull down");
    wr(ADDR_PP_DIR, 8'h81);
    chk(ppPullEn, 8'h3E, "pull off on outputs");
    wr(ADDR_PP_DATA, 8'hFF);
    rdChk(ADDR_PP_DATA, PP_IMPL_MASK, "port P data read");
    rdChk(ADDR_PP_IN, PP_IMPL_MASK, "port P pin read");
    rdChk(ADDR_PP_PULLEN, PP_IMPL_MASK, "pull readback");
    wr(ADDR_PP_POL, 8'h00);
    chk(ppPullDown, 8'h00, "pull up");
    wr(ADDR_PP_DIR, 8'h00);
    $display("test pull done");
  endtask : t_pull

  task automatic t_pinIrq;
    extDrv <= 8'hFE;
    cyc(2);
    wr(ADDR_PP_POL, 8'h01);
    wr(ADDR_PP_IE, 8'h01);
    wr(ADDR_PP_IFCLR, 8'hFF);
    chk({7'h00, pinIrq}, 8'h00, "irq idle");
    extDrv <= 8'hFF;
    cyc(2);
    chk({7'h00, pinIrq}, 8'h01, "rising edge irq");
    rdChk(ADDR_PP_IF, 8'h01, "flag held");
    wr(ADDR_PP_IFCLR, 8'h01);
    extDrv <= 8'hFC;
    cyc(2);
    rdChk(ADDR_PP_IF, 8'h02, "edge polarity");
    chk({7'h00, pinIrq}, 8'h00, "flag masked");
    wr(ADDR_PP_IE, 8'h02);
    chk({7'h00, pinIrq}, 8'h01, "flag unmasked");
    $display("test pin interrupt done");
  endtask : t_pinIrq

  task automatic t_analog;
    wr(ADDR_ANA_DIR, 8'hFF);
    rdChk(ADDR_ANA_DIR, 8'h03, "analog direction");
    wr(ADDR_ANA_DATA, 8'hA5);
    anaIn       <= 8'h5A;
    convDigInEn <= 8'hFF;
    cyc(1);
    chk(anaOutEnN, 8'hFC, "analog drive");
    chk(anaOut & 8'h03, 8'h01, "analog value");
    rdChk(ADDR_ANA_DATA, 8'h59, "analog mixed read");
    convDigInEn <= 8'h00;
    convClaim   <= 8'h01;
    cyc(1);
    rdChk(ADDR_ANA_DATA, 8'h01, "digital input off");
    chk(anaOutEnN, 8'hFD, "converter claim");
    $display("test analog done");
  endtask : t_analog

  task automatic t_portE;
    logic [7:0] s;
    wr(ADDR_CLKOUT, 8'hC0);
    coreRateClk  <= 1'b1;
    busRateClk   <= 1'b1;
    periphActive <= 8'h04;
    periphOut    <= 8'h04;
    periphOutEn  <= 8'h04;
    cyc(1);
    chk(peOut & 8'h94, 8'h94, "pe outputs high");
    chk(peOutEnN & 8'h94, 8'h00, "pe driven");
    coreRateClk <= 1'b0;
    busRateClk  <= 1'b0;
    cyc(1);
    chk(peOut & 8'h90, 8'h00, "pe clocks low");
    wr(ADDR_CLKOUT, 8'h42);
    for (int i = 0; i < 8; i++)
    begin
      cyc(1);
      s[i] = peOut[PE_BUS_PIN];
    end
    chk(s ^ {s[1:0], s[7:2]}, 8'hFF, "divided clock");
    wr(ADDR_IRQCTL, 8'h40);
    cpuIMask <= 1'b0;
    peIn     <= 8'hFD;
    cyc(1);
    chk({7'h00, extIrqReq}, 8'h01, "level request");
    cpuIMask <= 1'b1;
    cyc(1);
    chk({7'h00, extIrqReq}, 8'h00, "request masked");
    peIn     <= 8'hFF;
    cpuIMask <= 1'b0;
    wr(ADDR_IRQCTL, 8'hC0);
    peIn <= 8'hFD;
    cyc(3);
    peIn <= 8'hFF;
    cyc(1);
    chk({7'h00, extIrqReq}, 8'h01, "edge request held");
    extIrqAck <= 1'b1;
    cyc(1);
    extIrqAck <= 1'b0;
    cyc(1);
    chk({7'h00, extIrqReq}, 8'h00, "edge request acked");
    wr(ADDR_PE_DIR, 8'hFF);
    rdChk(ADDR_PE_DIR, 8'hFD, "pe pin one input only");
    chk(peOutEnN & 8'h02, 8'h02, "pe pin one released");
    $display("test port E done");
  endtask : t_portE

  task automatic t_route;
    pwmChanEn <= 6'h3F;
    pwmOut    <= 6'h15;
    wr(ADDR_ROUTE, 8'h3F);
    chk({2'h0, pwmAltOutEnN}, 8'h00, "routed drive");
    chk({2'h0, pwmAltOut}, 8'h15, "routed value");
    chk(ppOutEnN, 8'hFF, "default pins released");
    wr(ADDR_ROUTE, 8'h00);
    chk({2'h0, pwmAltOutEnN}, 8'h3F, "default pins");
    chk(ppOutEnN, 8'hC0, "default pins driven");
    chk(ppOut, 8'h15, "default pin values");
    $display("test routing done");
  endtask : t_route

  task automatic t_rst2;
    bkgdIn <= 1'b0;
    rst    <= 1'b1;
    cyc(2);
    rst    <= 1'b0;
    bkgdIn <= 1'b1;
    cyc(1);
    chk({7'h00, modeSelC}, 8'h00, "mode resampled");
    chk({7'h00, extIrqReq}, 8'h00, "request inhibited");
    rdChk(ADDR_MODE, 8'h00, "mode register resampled");
    $display("test second reset done");
  endtask : t_rst2

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  initial
  begin
    cyc(4000);
    mismatches++;
    conclude;
  end

  initial
  begin
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_pull;
    t_pinIrq;
    t_analog;
    t_portE;
    t_route;
    t_rst2;
    conclude;
  end
endmodule : ppc_port_pins_bench
